// ==== bdp_pkg.sv ====
// Purpose: Shared constants for the eight-bit bidirectional port block
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register
// Notes:   Every offset, field position and reset value lives here
package bdp_pkg;

    // Port geometry
    localparam int PORT_WIDTH = 8;            // Pins on the port
    localparam int HADDR_WIDTH = 8;           // Decoded address bits
    localparam int HDATA_WIDTH = 32;          // Bus data width

    // Register byte offsets
    localparam logic [7:0] OFS_PORT_DATA   = 8'h00; // Pin levels / output latch
    localparam logic [7:0] OFS_PORT_DIR    = 8'h04; // Per-pin direction
    localparam logic [7:0] OFS_PWM_STEER   = 8'h08; // Pulse-width steering
    localparam logic [7:0] OFS_ANALOG_SEL  = 8'h0C; // Per-pin analog select
    localparam logic [7:0] OFS_DATA_SET    = 8'h10; // Set latch bits, pin based
    localparam logic [7:0] OFS_DATA_CLR    = 8'h14; // Clear latch bits, pin based

    // Reset values
    localparam logic [7:0] DIR_RESET       = 8'hFF; // All pins inputs
    localparam logic [4:0] STEER_RESET     = 5'h01; // Output A steered only
    localparam logic [7:0] ANALOG_RESET    = 8'h00; // All pins digital

    // Steering register fields
    localparam int STEER_WIDTH    = 5;        // Implemented steering bits
    localparam int STEER_A_BIT    = 0;        // Steer output A
    localparam int STEER_B_BIT    = 1;        // Steer output B
    localparam int STEER_C_BIT    = 2;        // Steer output C
    localparam int STEER_D_BIT    = 3;        // Steer output D
    localparam int STEER_SYNC_BIT = 4;        // Steering sync select

    // Pins that carry the auxiliary pulse-width outputs
    localparam int PIN_AUX_B = 5;             // Auxiliary output B pin
    localparam int PIN_AUX_C = 6;             // Auxiliary output C pin
    localparam int PIN_AUX_D = 7;             // Auxiliary output D pin

    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2; // Bit 1 marks active transfer
    localparam int         HTRANS_ACT_BIT = 1;   // Active-transfer bit of htrans
    localparam logic       HRESP_OKAY    = 1'h0; // Only response given

    // Bus slave phases
    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b00,   // No data phase in progress
        BUS_WRITE  = 2'b01,   // Write data phase, zero wait
        BUS_RDWAIT = 2'b10,   // Read data phase, wait state
        BUS_RDOUT  = 2'b11    // Read data phase, data valid
    } bdp_bus_t;

endpackage

// ==== bdp_sync2.sv ====
// Purpose: Two-flop synchroniser for a group of asynchronous inputs
// Assumes: Each bit is independent; no bus coherency is promised
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module bdp_sync2 #(
    parameter int WIDTH = 8                   // Bits to synchronise
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // Data
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_r;               // Metastability catcher
    logic [WIDTH-1:0] stage2_r;               // Settled copy

    // Both stages clear to zero so reads are defined at once
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_r <= '0;
            stage2_r <= '0;
        end else begin
            stage1_r <= asyncIn;
            stage2_r <= stage1_r;
        end
    end

    assign syncOut = stage2_r;

endmodule

// ==== bdp_port_top.sv ====
// Purpose: Eight-bit bidirectional port with direction control and
//          pulse-width steering onto the three high pins
// Assumes: AHB-Lite slave, single word transfers, sys_clk at 40 MHz
// Notes:   Pin inputs pass two flops; reads see pins, not the latch
//
// Notes on behaviour
// - Eight pins, each with direction and latch
// - Direction one: pin input, driver off
// - Direction zero: drive latch value onto pin
// - Data read returns sampled pin levels
// - Set/clear writes merge into latch from sampled pins
// - Direction gates drivers even for analog pins
// - Analog pins read back as zero
// - Reset loads direction with all ones
// - Latch unset by power-up, kept across reset
// - Low five pins are plain I/O only
// - High three pins may carry outputs B-D
// - Steering register: sync, D,C,B,A; resets 0x01
`timescale 1ns/1ps
module bdp_port_top (
    // Clock and reset
    input  wire logic                              sys_clk,
    input  wire logic                              rst_n,
    // AHB-Lite slave
    input  wire logic                              hsel,
    input  wire logic [bdp_pkg::HADDR_WIDTH-1:0]   haddr,
    input  wire logic [1:0]                        htrans,
    input  wire logic                              hwrite,
    input  wire logic [2:0]                        hsize,
    input  wire logic [bdp_pkg::HDATA_WIDTH-1:0]   hwdata,
    input  wire logic                              hready,
    output logic      [bdp_pkg::HDATA_WIDTH-1:0]   hrdata,
    output logic                                   hreadyout,
    output logic                                   hresp,
    // Port pins, split into input, output and enable
    input  wire logic [bdp_pkg::PORT_WIDTH-1:0]    pinIn,
    output logic      [bdp_pkg::PORT_WIDTH-1:0]    pinOut,
    output logic      [bdp_pkg::PORT_WIDTH-1:0]    pinOe,
    // Pulse-width generator, same clock domain
    input  wire logic                              pwmAuxOutB,
    input  wire logic                              pwmAuxOutC,
    input  wire logic                              pwmAuxOutD,
    output logic                                   steerOutputA,
    output logic                                   steeringSyncSelect
);

    import bdp_pkg::*;

    // Register state
    logic [PORT_WIDTH-1:0]  fourthPortDirection_r;  // One means input
    logic [PORT_WIDTH-1:0]  fourthPortLatch_r;      // Output latch, no reset
    logic [PORT_WIDTH-1:0]  fourthPortLatch_nxt;    // Latch next value
    logic [STEER_WIDTH-1:0] pwmSteeringControl_r;   // Steering register
    logic [PORT_WIDTH-1:0]  analogSelect_r;         // One means analog pin

    // Bus slave state
    bdp_bus_t               busState_r;             // Data phase tracker
    bdp_bus_t               busState_nxt;           // Next phase
    logic [7:0]             dataAddr_r;             // Address held for data phase
    logic [HDATA_WIDTH-1:0] hrdata_r;               // Registered read data

    // Pin sampling
    logic [PORT_WIDTH-1:0]  pinSync;                // Pins after two flops
    logic [PORT_WIDTH-1:0]  pinRead;                // Pins as software sees them

    // Synchronise all eight pins before any logic looks at them
    bdp_sync2 #(
        .WIDTH   (PORT_WIDTH)
    ) u_pinSync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .asyncIn (pinIn),
        .syncOut (pinSync)
    );

    // Analog pins read as zero whatever the voltage
    assign pinRead = pinSync & ~analogSelect_r;

    // ------------------------------------------------------------
    // Address phase decode
    // ------------------------------------------------------------

    // Accept only while our own data phase is not stalling
    wire addrAccept = hsel && htrans[HTRANS_ACT_BIT] && hready && hreadyout;
    wire acceptWrite = addrAccept && hwrite;        // New write address phase
    wire acceptRead  = addrAccept && !hwrite;       // New read address phase

    // Byte address with the low two bits dropped; sub-word sizes not offered
    wire [7:0] addrWord = {haddr[7:2], 2'b00};

    // Data phase decode on the held address
    wire inWrite     = (busState_r == BUS_WRITE);
    wire selData     = (dataAddr_r == OFS_PORT_DATA);
    wire selDir      = (dataAddr_r == OFS_PORT_DIR);
    wire selSteer    = (dataAddr_r == OFS_PWM_STEER);
    wire selAnalog   = (dataAddr_r == OFS_ANALOG_SEL);
    wire selSet      = (dataAddr_r == OFS_DATA_SET);
    wire selClr      = (dataAddr_r == OFS_DATA_CLR);

    // Write strobes, one per register
    wire wrData      = inWrite && selData;
    wire wrDir       = inWrite && selDir;
    wire wrSteer     = inWrite && selSteer;
    wire wrAnalog    = inWrite && selAnalog;
    wire wrSet       = inWrite && selSet;
    wire wrClr       = inWrite && selClr;

    wire [PORT_WIDTH-1:0] wrByte = hwdata[PORT_WIDTH-1:0]; // Low lane carries data

    // ------------------------------------------------------------
    // Bus phase sequencing
    // ------------------------------------------------------------

    // Reads take one wait state so a write just before is visible
    always_comb begin
        busState_nxt = busState_r;
        case (busState_r)
            BUS_IDLE, BUS_WRITE, BUS_RDOUT: begin
                // Ready phases may take a new address phase
                if (acceptRead) begin
                    busState_nxt = BUS_RDWAIT;
                end else if (acceptWrite) begin
                    busState_nxt = BUS_WRITE;
                end else begin
                    busState_nxt = BUS_IDLE;
                end
            end
            BUS_RDWAIT: begin
                // Read data is captured now, shown next cycle
                busState_nxt = BUS_RDOUT;
            end
            default: begin
                busState_nxt = BUS_IDLE;
            end
        endcase
    end

    // Phase register and held address
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            busState_r <= BUS_IDLE;
            dataAddr_r <= 8'h00;
        end else begin
            busState_r <= busState_nxt;
            if (addrAccept) begin
                dataAddr_r <= addrWord;
            end
        end
    end

    // Stall only during the read wait state; every answer is OKAY
    assign hreadyout = (busState_r != BUS_RDWAIT);
    assign hresp     = HRESP_OKAY;

    // ------------------------------------------------------------
    // Read data path
    // ------------------------------------------------------------

    // Unmapped offsets read as zero
    wire [HDATA_WIDTH-1:0] readMux =
        selData   ? {{(HDATA_WIDTH-PORT_WIDTH){1'b0}}, pinRead}               :
        selDir    ? {{(HDATA_WIDTH-PORT_WIDTH){1'b0}}, fourthPortDirection_r} :
        selSteer  ? {{(HDATA_WIDTH-STEER_WIDTH){1'b0}}, pwmSteeringControl_r} :
        selAnalog ? {{(HDATA_WIDTH-PORT_WIDTH){1'b0}}, analogSelect_r}        :
        32'h0000_0000;

    // Capture read data at the end of the wait state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata_r <= 32'h0000_0000;
        end else if (busState_r == BUS_RDWAIT) begin
            hrdata_r <= readMux;
        end
    end

    assign hrdata = hrdata_r;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------

    // Direction, steering and analog select all reset to fixed values
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fourthPortDirection_r <= DIR_RESET;
            pwmSteeringControl_r  <= STEER_RESET;
            analogSelect_r        <= ANALOG_RESET;
        end else begin
            if (wrDir) begin
                fourthPortDirection_r <= wrByte;
            end
            if (wrSteer) begin
                pwmSteeringControl_r <= hwdata[STEER_WIDTH-1:0];
            end
            if (wrAnalog) begin
                analogSelect_r <= wrByte;
            end
        end
    end

    // ------------------------------------------------------------
    // Output latch
    // ------------------------------------------------------------

    // Set and clear updates start from the sampled pins, so a pin held
    // by an outside load can overwrite the bit that was driven
    always_comb begin
        fourthPortLatch_nxt = fourthPortLatch_r;
        if (wrData) begin
            // Whole byte addressed: pins read, all bits replaced
            fourthPortLatch_nxt = (pinRead & ~8'hFF) | wrByte;
        end else if (wrSet) begin
            // Chosen bits set, the rest copied from the pins
            fourthPortLatch_nxt = pinRead | wrByte;
        end else if (wrClr) begin
            // Chosen bits cleared, the rest copied from the pins
            fourthPortLatch_nxt = pinRead & ~wrByte;
        end
    end

    // No reset: contents are unknown at power-up and survive rst_n
    always_ff @(posedge sys_clk) begin
        fourthPortLatch_r <= fourthPortLatch_nxt;
    end

    // ------------------------------------------------------------
    // Pin output multiplexer
    // ------------------------------------------------------------

    // Steering enables for the three high pins
    wire steerB = pwmSteeringControl_r[STEER_B_BIT]; // Output B enable
    wire steerC = pwmSteeringControl_r[STEER_C_BIT]; // Output C enable
    wire steerD = pwmSteeringControl_r[STEER_D_BIT]; // Output D enable

    // Low five pins take the latch only; no alternate function
    assign pinOut[PIN_AUX_B-1:0] = fourthPortLatch_r[PIN_AUX_B-1:0];

    // High pins pick pulse-width or latch per steering bit
    assign pinOut[PIN_AUX_B] = steerB ? pwmAuxOutB : fourthPortLatch_r[PIN_AUX_B];
    assign pinOut[PIN_AUX_C] = steerC ? pwmAuxOutC : fourthPortLatch_r[PIN_AUX_C];
    assign pinOut[PIN_AUX_D] = steerD ? pwmAuxOutD : fourthPortLatch_r[PIN_AUX_D];

    // Driver enable follows direction alone, even for analog pins;
    // software must leave analog pins as inputs to avoid contention
    assign pinOe = ~fourthPortDirection_r;

    // Steering bits that the pulse-width generator itself consumes
    assign steerOutputA       = pwmSteeringControl_r[STEER_A_BIT];
    assign steeringSyncSelect = pwmSteeringControl_r[STEER_SYNC_BIT];

endmodule

// ==== bdp_port_properties.sv ====
// Purpose: Bus and pin timing checks for the port block
// Assumes: Sees only the top module ports, one clock domain
// Notes:   Bind statement sits after the module
`timescale 1ns/1ps
module bdp_port_properties (
    // Clock and reset
    input wire logic                            sys_clk,
    input wire logic                            rst_n,
    // Bus
    input wire logic                            hsel,
    input wire logic [1:0]                      htrans,
    input wire logic                            hwrite,
    input wire logic                            hready,
    input wire logic [bdp_pkg::HDATA_WIDTH-1:0] hrdata,
    input wire logic                            hreadyout,
    input wire logic                            hresp,
    // Pins and steering
    input wire logic [bdp_pkg::PORT_WIDTH-1:0]  pinOut,
    input wire logic [bdp_pkg::PORT_WIDTH-1:0]  pinOe,
    input wire logic                            steerOutputA,
    input wire logic                            steeringSyncSelect
);
    import bdp_pkg::*;
    // Transfer accepted at this edge
    wire taken = hsel & htrans[HTRANS_ACT_BIT] & hready & hreadyout;
    wire wrTaken = taken & hwrite;    // Write address phase accepted
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Values right after release of reset
    property p_reset_vals;
        $rose(rst_n) |-> pinOe == 8'h00 && steerOutputA && !steeringSyncSelect;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");
    property p_okay;
        hresp == HRESP_OKAY;
    endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_read_wait;
        taken && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait wrong");
    property p_write_nowait;
        wrTaken |=> hreadyout;
    endproperty
    a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
    // Drivers move only because of a write two edges back
    property p_oe_cause;
        $changed(pinOe) |-> $past(wrTaken, 2);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("enable moved alone");
    property p_steer_cause;
        $changed({steerOutputA, steeringSyncSelect}) |-> $past(wrTaken, 2);
    endproperty
    a_steer_cause: assert property (p_steer_cause) else $error("steer moved alone");
    // Low pins carry only the latch, no alternate source
    property p_out_cause;
        $changed(pinOut[4:0]) |-> $past(wrTaken, 2);
    endproperty
    a_out_cause: assert property (p_out_cause) else $error("low pins moved alone");
    property p_rdata_stand;
        $changed(hrdata) |-> !$past(hreadyout);
    endproperty
    a_rdata_stand: assert property (p_rdata_stand) else $error("read data moved");
endmodule
bind bdp_port_top bdp_port_properties u_props (.sys_clk, .rst_n, .hsel, .htrans, .hwrite,
    .hready, .hrdata, .hreadyout, .hresp, .pinOut, .pinOe, .steerOutputA, .steeringSyncSelect);

// ==== bdp_pin_model.sv ====
// Purpose: External circuitry on the eight port pins
// Assumes: No pull resistors on the pins
// Notes:   Undriven, unheld pins toggle so a stale value never passes
`timescale 1ns/1ps
module bdp_pin_model (
    // Clock
    input wire logic                           sys_clk,
    // Device side
    input wire logic [bdp_pkg::PORT_WIDTH-1:0] pinOut,
    input wire logic [bdp_pkg::PORT_WIDTH-1:0] pinOe,
    // Bench control of external drivers
    input wire logic [bdp_pkg::PORT_WIDTH-1:0] extVal,
    input wire logic [bdp_pkg::PORT_WIDTH-1:0] extEn,
    // Resolved wire level
    output logic     [bdp_pkg::PORT_WIDTH-1:0] pinIn
);
    logic [7:0] noise_r = 8'h55;      // Floating-pin pattern
    // Pattern changes every cycle
    // Plain always, since the declaration already gives the start value
    always @(posedge sys_clk) begin
        noise_r <= ~noise_r;
    end
    // Device drive wins where enabled, else external or float
    assign pinIn = (pinOe & pinOut) | (~pinOe & extEn & extVal) | (~pinOe & ~extEn & noise_r);
endmodule

// ==== tb_bidir_eight_bit_port.sv ====
// Purpose: Register-level tests of the port block
// Assumes: One AHB-Lite master, word transfers only
// Notes:   Pin expectations worked out by hand per scenario
`timescale 1ns/1ps
module tb_bidir_eight_bit_port;
    import bdp_pkg::*;
    logic        sys_clk = 1'b0;      // 40 MHz
    logic        rst_n   = 1'b0;      // Held at start
    logic        hsel    = 1'b0;
    logic [7:0]  haddr   = 8'h00;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [31:0] hwdata  = 32'h0;
    logic [31:0] hrdata, q;
    logic        hreadyout, hresp, steerA, syncSel;
    logic [7:0]  pinIn, pinOut, pinOe;
    logic [7:0]  extVal  = 8'hA5;     // External pin levels
    logic [7:0]  extEn   = 8'hFF;
    logic        pwmB = 1'b0, pwmC = 1'b0, pwmD = 1'b0;
    int          n_mismatch = 0, num_checks = 0, cycles = 0;
    always #12.5 sys_clk = ~sys_clk;
    bdp_port_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pinIn(pinIn), .pinOut(pinOut),
        .pinOe(pinOe), .pwmAuxOutB(pwmB), .pwmAuxOutC(pwmC), .pwmAuxOutD(pwmD),
        .steerOutputA(steerA), .steeringSyncSelect(syncSel));
    bdp_pin_model u_pins (.sys_clk(sys_clk), .pinOut(pinOut), .pinOe(pinOe), .extVal(extVal),
        .extEn(extEn), .pinIn(pinIn));
    // Hang guard; whole run is about a hundred cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            results();
        end
    end
    task results;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // Look in mid-cycle, return just after the edge that saw ready
    task waitRdy;
        @(negedge sys_clk);
        while (hreadyout !== 1'b1) @(negedge sys_clk);
        q = hrdata;
        @(posedge sys_clk);
    endtask
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        waitRdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy();
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        xfer(a, 1'b1, {24'h0, d});
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(q, exp);
    endtask
    // Pin outputs, once the write has landed
    task pchk(input logic [7:0] oe, input logic [7:0] out);
        @(negedge sys_clk);
        chk({24'h0, pinOe}, {24'h0, oe});
        chk({24'h0, pinOut}, {24'h0, out});
        @(posedge sys_clk);
    endtask
    // Two sync flops plus margin before pins are read
    task settle;
        repeat (3) @(posedge sys_clk);
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rd(OFS_PORT_DIR, 32'hFF);
        rd(OFS_PWM_STEER, 32'h01);
        chk({24'h0, pinOe}, 32'h0);
        rd(OFS_PORT_DATA, 32'hA5);
        wr(OFS_PORT_DATA, 8'h3C);
        rd(OFS_PORT_DATA, 32'hA5);
        wr(OFS_PORT_DIR, 8'h00);
        pchk(8'hFF, 8'h3C);
        settle();
        rd(OFS_PORT_DATA, 32'h3C);
        // High nibble inputs (direction one): set and clear pick up pin levels
        wr(OFS_PORT_DIR, 8'hF0);
        settle();
        wr(OFS_DATA_SET, 8'h01);
        pchk(8'h0F, 8'hAD);
        settle();
        wr(OFS_DATA_CLR, 8'h0C);
        pchk(8'h0F, 8'hA1);
        // Analog pins read as zero, then analog pin 0 is still driven by direction
        wr(OFS_PORT_DIR, 8'hFF);
        wr(OFS_ANALOG_SEL, 8'h03);
        settle();
        rd(OFS_PORT_DATA, 32'hA4);
        wr(OFS_PORT_DIR, 8'hFE);
        pchk(8'h01, 8'hA1);
        wr(OFS_ANALOG_SEL, 8'h00);
        // Steer B, C, D with sync, output A off
        pwmC <= 1'b1;
        wr(OFS_PWM_STEER, 8'hFE);
        pchk(8'h01, 8'h41);
        chk({30'h0, syncSel, steerA}, 32'h2);
        rd(OFS_PWM_STEER, 32'h1E);
        wr(OFS_PORT_DIR, 8'hFF);
        pchk(8'h00, 8'h41);
        // Unmapped place: ignored, reads zero
        wr(8'h20, 8'h00);
        rd(8'h20, 32'h0);
        rd(OFS_PORT_DIR, 32'hFF);
        // Reset in mid-run keeps the latch
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        pchk(8'h00, 8'hA1);
        rd(OFS_PWM_STEER, 32'h01);
        results();
    end
endmodule
